// *** verilog/dsrp_pkg.sv ***
// Constants and types shared by the dual mode serial register port.
package dsrp_pkg;
    localparam int ADDR_W       = 7;
    localparam int DATA_W       = 8;
    localparam logic [6:0] ADDR_MAX = 7'h7F;
    localparam logic [6:0] ADDR_RST = 7'h00;
    localparam logic [7:0] DATA_RST = 8'h00;
    // Fixed part of the bus address; the value is arbitrary.
    localparam logic [5:0] I2C_FIX_DEF = 6'h2A;
    localparam int CLK_KHZ_DEF  = 25000;
    localparam int STD_KBPS     = 100;
    localparam int FAST_KBPS    = 400;
    localparam int MIN_SAMPLES  = 16;
    localparam int CLK_NS       = 40;
    localparam int RST_MIN_NS   = 300;
    localparam int RST_MIN_CYC  = (RST_MIN_NS + CLK_NS - 1) / CLK_NS;
    localparam int NPIN         = 5;
    localparam int PIN_SCK      = 0;
    localparam int PIN_SDI      = 1;
    localparam int PIN_CSA      = 2;
    localparam int PIN_RSTN     = 3;
    localparam int PIN_MODE     = 4;
    typedef enum logic [0:0] {SPI_HDR, SPI_DATA} dsrp_spi_st_t;
    typedef enum logic [2:0] {
        I2C_IDLE, I2C_DEV, I2C_REG, I2C_WR, I2C_RD, I2C_MACK, I2C_ACK
    } dsrp_i2c_st_t;
endpackage : dsrp_pkg

// *** verilog/dsrp_port.sv ***
// Serial register port with SPI and I2C slave front ends.
// Functional notes
// - Strap high or floating selects I2C, low SPI.
// - Clock level at select picks bit order.
// - SPI frames: 7-bit address, 8-bit data bytes.
// - Select high holds SPI logic in reset.
// - First SPI bit: 1 read, 0 write.
// - SPI burst increments address after each byte.
// - Half duplex: input ignored while reading.
// - I2C slave only, 7-bit addressing, 400 kbit/s.
// - I2C bytes whole, most significant bit first.
// - Slave address: fixed six bits plus pin.
// - I2C burst uses incremented address per byte.
// - I2C increment stops at 0x7F, no wrap.
// - Released reset restores configuration defaults.
`timescale 1ns/10ps
`default_nettype none
module dsrp_port
    import dsrp_pkg::*;
#(
    parameter int         CLK_KHZ      = CLK_KHZ_DEF,
    parameter logic [5:0] I2C_FIX_ADDR = I2C_FIX_DEF
) (
    input  wire logic              sys_clk,
    input  wire logic              sys_rst,
    input  wire logic              rst_n_pin,
    input  wire logic              i2c_en_pin,
    input  wire logic              sck_scl_pin,
    input  wire logic              si_sda_pin,
    input  wire logic              chip_select_or_addr_bit_pin,
    output logic                   sda_o_ff,
    output logic                   sda_oe_ff,
    output logic                   so_ff,
    output logic                   so_oe_ff,
    output logic                   dev_rst_ff,
    output logic                   i2c_mode_ff,
    output logic [ADDR_W-1:0]      reg_addr_ff,
    output logic [DATA_W-1:0]      reg_wdata_ff,
    output logic                   reg_wr_ff,
    output logic                   reg_rd_ff,
    input  wire logic [DATA_W-1:0] reg_rdata
);
    if (CLK_KHZ < MIN_SAMPLES * FAST_KBPS) begin : g_chk
        $error("Clock too slow to sample the fast serial rate.");
    end

    logic [NPIN-1:0] pin_vec;
    logic [NPIN-1:0] s1_ff;
    logic [NPIN-1:0] s2_ff;
    logic [NPIN-1:0] s3_ff;
    assign pin_vec[PIN_SCK]  = sck_scl_pin;
    assign pin_vec[PIN_SDI]  = si_sda_pin;
    assign pin_vec[PIN_CSA]  = chip_select_or_addr_bit_pin;
    assign pin_vec[PIN_RSTN] = rst_n_pin;
    assign pin_vec[PIN_MODE] = i2c_en_pin;

    // Every pin passes two flops; the third only feeds edge detection.
    for (genvar i = 0; i < NPIN; i++) begin : g_sync
        always_ff @(posedge sys_clk or posedge sys_rst) begin
            if (sys_rst) begin
                s1_ff[i] <= 1'b1;
                s2_ff[i] <= 1'b1;
                s3_ff[i] <= 1'b1;
            end else begin
                s1_ff[i] <= pin_vec[i];
                s2_ff[i] <= s1_ff[i];
                s3_ff[i] <= s2_ff[i];
            end
        end
    end

    wire sck_rise = s2_ff[PIN_SCK] & ~s3_ff[PIN_SCK];
    wire sck_fall = ~s2_ff[PIN_SCK] & s3_ff[PIN_SCK];
    wire sdi      = s2_ff[PIN_SDI];
    wire scl_hi   = s2_ff[PIN_SCK] & s3_ff[PIN_SCK];
    wire i2c_start = scl_hi & s3_ff[PIN_SDI] & ~s2_ff[PIN_SDI];
    wire i2c_stop  = scl_hi & ~s3_ff[PIN_SDI] & s2_ff[PIN_SDI];
    wire cs_fall  = ~s2_ff[PIN_CSA] & s3_ff[PIN_CSA];
    wire spi_run  = ~i2c_mode_ff & ~s2_ff[PIN_CSA] & ~dev_rst_ff;
    wire i2c_run  = i2c_mode_ff & ~dev_rst_ff;
    wire [6:0] my_addr = {I2C_FIX_ADDR, s2_ff[PIN_CSA]};

    // Reset pin is stretched by the least legal low time.
    logic [3:0] rcnt_ff;
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            rcnt_ff    <= 4'(RST_MIN_CYC);
            dev_rst_ff <= 1'b1;
        end else if (!s2_ff[PIN_RSTN]) begin
            rcnt_ff    <= 4'(RST_MIN_CYC);
            dev_rst_ff <= 1'b1;
        end else begin
            rcnt_ff    <= (rcnt_ff != 4'h0) ? rcnt_ff - 4'h1 : 4'h0;
            dev_rst_ff <= (rcnt_ff != 4'h0);
        end
    end

    // The interface strap is caught while the port is held in reset.
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            i2c_mode_ff <= 1'b1;
        end else if (dev_rst_ff) begin
            i2c_mode_ff <= s2_ff[PIN_MODE];
        end
    end

    // SPI slave.
    dsrp_spi_st_t sp_st_ff;
    logic [2:0]   sp_cnt_ff;
    logic         sp_lsb_ff;
    logic         sp_rw_ff;
    logic [6:0]   sp_addr_ff;
    logic [7:0]   sp_sh_ff;
    logic         sp_wr_ff;
    logic         sp_rd_ff;
    logic         sp_inc_ff;
    logic [7:0]   rdata_ff;
    wire  [6:0]   sp_addr_in = sp_lsb_ff ? {sdi, sp_addr_ff[6:1]}
                                         : {sp_addr_ff[5:0], sdi};
    wire  [7:0]   sp_byte_in = sp_lsb_ff ? {sdi, sp_sh_ff[7:1]}
                                         : {sp_sh_ff[6:0], sdi};
    wire  [2:0]   sp_bit_idx = sp_lsb_ff ? sp_cnt_ff : 3'h7 - sp_cnt_ff;

    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            sp_st_ff   <= SPI_HDR;
            sp_cnt_ff  <= 3'h0;
            sp_lsb_ff  <= 1'b0;
            sp_rw_ff   <= 1'b0;
            sp_addr_ff <= ADDR_RST;
            sp_sh_ff   <= DATA_RST;
            sp_wr_ff   <= 1'b0;
            sp_rd_ff   <= 1'b0;
            sp_inc_ff  <= 1'b0;
        end else if (!spi_run) begin
            sp_st_ff  <= SPI_HDR;
            sp_cnt_ff <= 3'h0;
            sp_wr_ff  <= 1'b0;
            sp_rd_ff  <= 1'b0;
            sp_inc_ff <= 1'b0;
        end else begin
            sp_wr_ff  <= 1'b0;
            sp_rd_ff  <= 1'b0;
            sp_inc_ff <= 1'b0;
            if (sp_inc_ff) begin
                sp_addr_ff <= sp_addr_ff + 7'h01;
            end
            if (cs_fall) begin
                sp_lsb_ff <= s2_ff[PIN_SCK];
                sp_st_ff  <= SPI_HDR;
                sp_cnt_ff <= 3'h0;
            end else if (sck_rise) begin
                sp_cnt_ff <= sp_cnt_ff + 3'h1;
                case (sp_st_ff)
                    SPI_HDR: begin
                        if (sp_cnt_ff == 3'h0) begin
                            sp_rw_ff <= sdi;
                        end else begin
                            sp_addr_ff <= sp_addr_in;
                        end
                        if (sp_cnt_ff == 3'h7) begin
                            sp_st_ff <= SPI_DATA;
                            sp_rd_ff <= sp_rw_ff;
                        end
                    end
                    SPI_DATA: begin
                        if (!sp_rw_ff) begin
                            sp_sh_ff <= sp_byte_in;
                        end
                        if (sp_cnt_ff == 3'h7) begin
                            sp_wr_ff  <= ~sp_rw_ff;
                            sp_inc_ff <= ~sp_rw_ff;
                            if (sp_rw_ff) begin
                                sp_addr_ff <= sp_addr_ff + 7'h01;
                                sp_rd_ff   <= 1'b1;
                            end
                        end
                    end
                    default: sp_st_ff <= SPI_HDR;
                endcase
            end
        end
    end

    // Serial output is driven only in the data phase of a read.
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            so_ff    <= 1'b0;
            so_oe_ff <= 1'b0;
        end else if (!spi_run || !sp_rw_ff || sp_st_ff != SPI_DATA) begin
            so_ff    <= 1'b0;
            so_oe_ff <= 1'b0;
        end else if (sck_fall) begin
            so_ff    <= rdata_ff[sp_bit_idx];
            so_oe_ff <= 1'b1;
        end
    end

    // I2C slave.
    dsrp_i2c_st_t ic_st_ff;
    dsrp_i2c_st_t ic_nxt_ff;
    logic [2:0]   ic_cnt_ff;
    logic [6:0]   ic_addr_ff;
    logic [7:0]   ic_sh_ff;
    logic         ic_ovf_ff;
    logic         ic_ackon_ff;
    logic         ic_wr_ff;
    logic         ic_rd_ff;
    logic         ic_inc_ff;
    wire  [7:0]   ic_byte  = {ic_sh_ff[6:0], sdi};
    wire          ic_last  = ic_ovf_ff | (ic_addr_ff == ADDR_MAX);
    wire  [2:0]   ic_bit   = 3'h7 - ic_cnt_ff;
    wire          ic_rx    = (ic_st_ff == I2C_DEV) | (ic_st_ff == I2C_REG)
                           | (ic_st_ff == I2C_WR);

    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            ic_st_ff    <= I2C_IDLE;
            ic_nxt_ff   <= I2C_IDLE;
            ic_cnt_ff   <= 3'h0;
            ic_addr_ff  <= ADDR_RST;
            ic_sh_ff    <= DATA_RST;
            ic_ovf_ff   <= 1'b0;
            ic_ackon_ff <= 1'b0;
            ic_wr_ff    <= 1'b0;
            ic_rd_ff    <= 1'b0;
            ic_inc_ff   <= 1'b0;
            sda_oe_ff   <= 1'b0;
            sda_o_ff    <= 1'b0;
        end else if (!i2c_run) begin
            ic_st_ff    <= I2C_IDLE;
            ic_ackon_ff <= 1'b0;
            ic_wr_ff    <= 1'b0;
            ic_rd_ff    <= 1'b0;
            ic_inc_ff   <= 1'b0;
            sda_oe_ff   <= 1'b0;
            if (dev_rst_ff) begin
                ic_addr_ff <= ADDR_RST;
                ic_ovf_ff  <= 1'b0;
            end
        end else begin
            ic_wr_ff  <= 1'b0;
            ic_rd_ff  <= 1'b0;
            ic_inc_ff <= 1'b0;
            if (ic_inc_ff) begin
                if (ic_addr_ff == ADDR_MAX) begin
                    ic_ovf_ff <= 1'b1;
                end else begin
                    ic_addr_ff <= ic_addr_ff + 7'h01;
                end
            end
            if (i2c_start) begin
                ic_st_ff    <= I2C_DEV;
                ic_cnt_ff   <= 3'h0;
                ic_ackon_ff <= 1'b0;
                sda_oe_ff   <= 1'b0;
            end else if (i2c_stop) begin
                ic_st_ff  <= I2C_IDLE;
                sda_oe_ff <= 1'b0;
            end else if (sck_rise && ic_rx) begin
                ic_sh_ff  <= ic_byte;
                ic_cnt_ff <= ic_cnt_ff + 3'h1;
                if (ic_cnt_ff == 3'h7) begin
                    ic_st_ff <= I2C_ACK;
                    case (ic_st_ff)
                        I2C_DEV: begin
                            if (ic_byte[7:1] != my_addr) begin
                                ic_st_ff <= I2C_IDLE;
                            end
                            ic_nxt_ff <= ic_byte[0] ? I2C_RD : I2C_REG;
                            ic_rd_ff  <= ic_byte[0] & ~ic_ovf_ff
                                       & (ic_byte[7:1] == my_addr);
                        end
                        I2C_REG: begin
                            ic_addr_ff <= ic_byte[6:0];
                            ic_ovf_ff  <= 1'b0;
                            ic_nxt_ff  <= I2C_WR;
                        end
                        default: begin
                            ic_wr_ff  <= ~ic_ovf_ff;
                            ic_inc_ff <= ~ic_ovf_ff;
                            ic_nxt_ff <= I2C_WR;
                        end
                    endcase
                end
            end else if (sck_rise && ic_st_ff == I2C_RD) begin
                ic_cnt_ff <= ic_cnt_ff + 3'h1;
                if (ic_cnt_ff == 3'h7) begin
                    ic_st_ff <= I2C_MACK;
                end
            end else if (sck_rise && ic_st_ff == I2C_MACK) begin
                ic_cnt_ff <= 3'h0;
                ic_st_ff  <= sdi ? I2C_IDLE : I2C_RD;
                if (!sdi) begin
                    ic_ovf_ff  <= ic_last;
                    ic_rd_ff   <= ~ic_last;
                    ic_addr_ff <= ic_last ? ic_addr_ff
                                          : ic_addr_ff + 7'h01;
                end
            end else if (sck_fall) begin
                case (ic_st_ff)
                    I2C_ACK: begin
                        ic_ackon_ff <= ~ic_ackon_ff;
                        sda_oe_ff   <= ~ic_ackon_ff;
                        if (ic_ackon_ff) begin
                            ic_st_ff  <= ic_nxt_ff;
                            ic_cnt_ff <= 3'h0;
                            if (ic_nxt_ff == I2C_RD) begin
                                sda_oe_ff <= ~ic_ovf_ff & ~rdata_ff[7];
                            end
                        end
                    end
                    I2C_RD: sda_oe_ff <= ~ic_ovf_ff & ~rdata_ff[ic_bit];
                    default: sda_oe_ff <= 1'b0;
                endcase
            end
        end
    end

    // Register side: one of the two front ends owns it, chosen by the strap.
    wire       sel_wr   = i2c_mode_ff ? ic_wr_ff : sp_wr_ff;
    wire       sel_rd   = i2c_mode_ff ? ic_rd_ff : sp_rd_ff;
    wire [6:0] sel_addr = i2c_mode_ff ? ic_addr_ff : sp_addr_ff;
    wire [7:0] sel_data = i2c_mode_ff ? ic_sh_ff : sp_sh_ff;

    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            reg_addr_ff  <= ADDR_RST;
            reg_wdata_ff <= DATA_RST;
            reg_wr_ff    <= 1'b0;
            reg_rd_ff    <= 1'b0;
            rdata_ff     <= DATA_RST;
        end else begin
            reg_addr_ff  <= sel_addr;
            reg_wdata_ff <= sel_data;
            reg_wr_ff    <= sel_wr & ~dev_rst_ff;
            reg_rd_ff    <= sel_rd & ~dev_rst_ff;
            if (reg_rd_ff) begin
                rdata_ff <= reg_rdata;
            end
        end
    end
endmodule : dsrp_port
`default_nettype wire

// *** testbench/dsrp_port_assertions.sv ***
// Port assertions for the dual mode serial register port.
`timescale 1ns/10ps
`default_nettype none
module dsrp_port_chk
    import dsrp_pkg::*;
(
    input wire logic              sys_clk,
    input wire logic              sys_rst,
    input wire logic              rst_n_pin,
    input wire logic              i2c_en_pin,
    input wire logic              sck_scl_pin,
    input wire logic              si_sda_pin,
    input wire logic              chip_select_or_addr_bit_pin,
    input wire logic              sda_o_ff,
    input wire logic              sda_oe_ff,
    input wire logic              so_ff,
    input wire logic              so_oe_ff,
    input wire logic              dev_rst_ff,
    input wire logic              i2c_mode_ff,
    input wire logic [ADDR_W-1:0] reg_addr_ff,
    input wire logic [DATA_W-1:0] reg_wdata_ff,
    input wire logic              reg_wr_ff,
    input wire logic              reg_rd_ff,
    input wire logic [DATA_W-1:0] reg_rdata
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (sys_rst);
    sequence s_cs_idle;
        chip_select_or_addr_bit_pin [*5] ##0 !i2c_mode_ff;
    endsequence
    sequence s_pin_low;
        !rst_n_pin [*5];
    endsequence
    a_sda_open_drain: assert property (sda_oe_ff |-> !sda_o_ff)
        else $error("SDA driven high");
    a_wr_single: assert property (reg_wr_ff |=> !reg_wr_ff)
        else $error("Write strobe too long");
    a_rd_single: assert property (reg_rd_ff |=> !reg_rd_ff)
        else $error("Read strobe too long");
    a_spi_sda_off: assert property (!i2c_mode_ff |-> !sda_oe_ff)
        else $error("SDA driven in SPI mode");
    a_i2c_so_off: assert property (i2c_mode_ff |-> !so_oe_ff)
        else $error("SO driven in I2C mode");
    a_cs_high_off: assert property (s_cs_idle |-> !so_oe_ff)
        else $error("SO driven with select high");
    a_rst_quiet: assert property (dev_rst_ff |-> !(reg_wr_ff || reg_rd_ff))
        else $error("Access during reset");
    a_pin_rst_takes: assert property (s_pin_low |-> dev_rst_ff)
        else $error("Reset pin ignored");
    a_rst_stretch: assert property ($rose(rst_n_pin) |-> ##1 dev_rst_ff [*8])
        else $error("Reset released early");
    a_mode_frozen: assert property
        (!dev_rst_ff && !$past(dev_rst_ff) |-> $stable(i2c_mode_ff))
        else $error("Mode changed outside reset");
endmodule : dsrp_port_chk
bind dsrp_port dsrp_port_chk u_chk (.sys_clk(sys_clk), .sys_rst(sys_rst),
    .rst_n_pin(rst_n_pin), .i2c_en_pin(i2c_en_pin),
    .sck_scl_pin(sck_scl_pin), .si_sda_pin(si_sda_pin),
    .chip_select_or_addr_bit_pin(chip_select_or_addr_bit_pin),
    .sda_o_ff(sda_o_ff), .sda_oe_ff(sda_oe_ff), .so_ff(so_ff),
    .so_oe_ff(so_oe_ff), .dev_rst_ff(dev_rst_ff), .i2c_mode_ff(i2c_mode_ff),
    .reg_addr_ff(reg_addr_ff), .reg_wdata_ff(reg_wdata_ff),
    .reg_wr_ff(reg_wr_ff), .reg_rd_ff(reg_rd_ff), .reg_rdata(reg_rdata));
`default_nettype wire

// *** testbench/dsrp_host.sv ***
// Host model that masters the SPI and I2C links.
`timescale 1ns/10ps
`default_nettype none
module dsrp_host (
    input  wire logic sys_clk,
    input  wire logic sda_in,
    input  wire logic so,
    output var logic  sck,
    output var logic  sda_drv,
    output var logic  cs
);
    initial begin
        sck = 1'b1;
        sda_drv = 1'b1;
        cs = 1'b1;
    end
    task automatic hc(input int n);
        repeat (n) @(posedge sys_clk);
    endtask : hc
    // Idle clock level before select picks the bit order.
    task automatic spi_begin(input logic lsb);
        sck <= lsb;
        hc(4);
        cs <= 1'b0;
        hc(4);
    endtask : spi_begin
    // One whole byte; data goes out on the fall, is read before the rise.
    task automatic spi_byte(input logic lsb, input logic [7:0] b,
                            output logic [7:0] r);
        for (int i = 0; i < 8; i++) begin
            sck <= 1'b0;
            sda_drv <= b[lsb ? i : 7 - i];
            hc(4);
            r[lsb ? i : 7 - i] = so;
            sck <= 1'b1;
            hc(4);
        end
    endtask : spi_byte
    task automatic spi_end(input logic lsb);
        sck <= lsb;
        hc(4);
        cs <= 1'b1;
        hc(8);
    endtask : spi_end
    // Nine clocks, most significant first; a one releases the line.
    task automatic i2c_bits(input logic [8:0] tx, output logic [8:0] rx);
        for (int i = 8; i >= 0; i--) begin
            sck <= 1'b0;
            hc(2);
            sda_drv <= tx[i];
            hc(2);
            sck <= 1'b1;
            hc(3);
            rx[i] = sda_in;
            hc(1);
        end
    endtask : i2c_bits
    task automatic i2c_start;
        sck <= 1'b0;
        hc(2);
        sda_drv <= 1'b1;
        hc(2);
        sck <= 1'b1;
        hc(4);
        sda_drv <= 1'b0;
        hc(4);
    endtask : i2c_start
    task automatic i2c_stop;
        sck <= 1'b0;
        hc(2);
        sda_drv <= 1'b0;
        hc(2);
        sck <= 1'b1;
        hc(4);
        sda_drv <= 1'b1;
        hc(8);
    endtask : i2c_stop
endmodule : dsrp_host
`default_nettype wire

// *** testbench/dsrp_port_tb.sv ***
// Self-checking bench for the dual mode serial register port.
`timescale 1ns/10ps
`default_nettype none
module dsrp_port_tb;
    import dsrp_pkg::*;
    logic              sys_clk, sys_rst, rst_n_pin, i2c_en_pin;
    logic              sck, sda_drv, cs, sda_o, sda_oe, so, so_oe;
    logic              dev_rst, i2c_mode, reg_wr, reg_rd;
    logic [6:0]        reg_addr;
    logic [7:0]        reg_wdata, reg_rdata, r;
    logic [8:0]        rx;
    logic [14:0]       wlog[$];
    int                num_errors = 0;
    int                tests_run = 0;
    wire logic         sda_w = sda_drv & ~sda_oe;
    assign reg_rdata = {1'b1, reg_addr} ^ 8'h3C;
    dsrp_port dut (.sys_clk(sys_clk), .sys_rst(sys_rst),
        .rst_n_pin(rst_n_pin), .i2c_en_pin(i2c_en_pin), .sck_scl_pin(sck),
        .si_sda_pin(sda_w), .chip_select_or_addr_bit_pin(cs),
        .sda_o_ff(sda_o), .sda_oe_ff(sda_oe), .so_ff(so), .so_oe_ff(so_oe),
        .dev_rst_ff(dev_rst), .i2c_mode_ff(i2c_mode), .reg_addr_ff(reg_addr),
        .reg_wdata_ff(reg_wdata), .reg_wr_ff(reg_wr), .reg_rd_ff(reg_rd),
        .reg_rdata(reg_rdata));
    dsrp_host host (.sys_clk(sys_clk), .sda_in(sda_w), .so(so), .sck(sck),
        .sda_drv(sda_drv), .cs(cs));
    initial begin
        sys_clk = 1'b0;
        forever #20 sys_clk = ~sys_clk;
    end
    always @(posedge sys_clk) begin
        if (reg_wr === 1'b1) wlog.push_back({reg_addr, reg_wdata});
    end
    function automatic logic [7:0] core(input logic [6:0] a);
        return {1'b1, a} ^ 8'h3C;
    endfunction : core
    task automatic chk(input string nm, input logic [15:0] e, g);
        tests_run++;
        if (e !== g) begin
            num_errors++;
            $display("wrong value %s expected %h seen %h", nm, e, g);
        end
    endtask : chk
    task automatic chk_log(input int n, input logic [6:0] a, input logic [7:0] d);
        chk("write count", 16'(n), 16'(wlog.size()));
        for (int i = 0; i < n && i < wlog.size(); i++)
            chk("write", {1'b0, 7'(a + i), 8'(d + i)}, {1'b0, wlog[i]});
        wlog.delete();
    endtask : chk_log
    task automatic ack_tx(input logic [7:0] b, input logic nak);
        host.i2c_bits({b, 1'b1}, rx);
        chk("ack", {15'h0, nak}, {15'h0, rx[0]});
    endtask : ack_tx
    task automatic t_spi_write;
        host.spi_begin(1'b0);
        host.spi_byte(1'b0, {1'b0, 7'h7E}, r);
        for (int i = 0; i < 3; i++) host.spi_byte(1'b0, 8'hC0 + 8'(i), r);
        host.spi_end(1'b0);
        chk_log(3, 7'h7E, 8'hC0);
    endtask : t_spi_write
    task automatic t_spi_read;
        host.spi_begin(1'b1);
        host.spi_byte(1'b1, {7'h10, 1'b1}, r);
        host.spi_byte(1'b1, 8'h5A, r);
        chk("read 0", {8'h0, core(7'h10)}, {8'h0, r});
        host.spi_byte(1'b1, 8'hA5, r);
        chk("read 1", {8'h0, core(7'h11)}, {8'h0, r});
        host.spi_end(1'b1);
        chk_log(0, 7'h00, 8'h00);
    endtask : t_spi_read
    task automatic t_spi_abort;
        host.spi_begin(1'b0);
        host.spi_byte(1'b0, 8'h05, r);
        host.spi_end(1'b0);
        host.spi_begin(1'b0);
        host.spi_byte(1'b0, 8'h33, r);
        host.spi_byte(1'b0, 8'h44, r);
        host.spi_end(1'b0);
        chk_log(1, 7'h33, 8'h44);
    endtask : t_spi_abort
    task automatic t_i2c;
        i2c_en_pin <= 1'b1;
        rst_n_pin <= 1'b0;
        host.hc(10);
        rst_n_pin <= 1'b1;
        host.hc(20);
        chk("mode", 16'h1, {15'h0, i2c_mode});
        host.i2c_start;
        ack_tx(8'hAB, 1'b0);
        host.i2c_bits({8'hFF, 1'b1}, rx);
        chk("reset pointer", {8'h0, core(7'h00)}, {8'h0, rx[8:1]});
        host.i2c_stop;
        host.i2c_start;
        ack_tx(8'hAA, 1'b0);
        ack_tx(8'h7E, 1'b0);
        ack_tx(8'h11, 1'b0);
        ack_tx(8'h12, 1'b0);
        ack_tx(8'h13, 1'b0);
        host.i2c_stop;
        chk_log(2, 7'h7E, 8'h11);
        host.i2c_start;
        ack_tx(8'hAA, 1'b0);
        ack_tx(8'h20, 1'b0);
        host.i2c_start;
        ack_tx(8'hAB, 1'b0);
        host.i2c_bits({8'hFF, 1'b0}, rx);
        chk("i2c read 0", {8'h0, core(7'h20)}, {8'h0, rx[8:1]});
        host.i2c_bits({8'hFF, 1'b1}, rx);
        chk("i2c read 1", {8'h0, core(7'h21)}, {8'h0, rx[8:1]});
        host.i2c_stop;
        host.i2c_start;
        ack_tx(8'hA8, 1'b1);
        host.i2c_stop;
    endtask : t_i2c
    task automatic finish_test;
        $display("errors %0d checks %0d", num_errors, tests_run);
        if (num_errors == 0 && tests_run > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : finish_test
    initial begin
        host.hc(20000);
        num_errors++;
        finish_test;
    end
    initial begin
        sys_rst = 1'b1;
        rst_n_pin = 1'b0;
        i2c_en_pin = 1'b0;
        host.hc(2);
        sys_rst <= 1'b0;
        host.hc(8);
        rst_n_pin <= 1'b1;
        host.hc(20);
        chk("mode", 16'h0, {15'h0, i2c_mode});
        t_spi_write;
        t_spi_read;
        t_spi_abort;
        t_i2c;
        finish_test;
    end
endmodule : dsrp_port_tb
`default_nettype wire
